// file: rtl/gio_map.vh
// Address map, field masks and reset values of the general I/O ports
`ifndef GIO_MAP_VH
`define GIO_MAP_VH

// File addresses of the five port data registers
`define GIO_ADDR_W        5
`define GIO_ADDR_BANK_A   5'h05
`define GIO_ADDR_BANK_B   5'h06
`define GIO_ADDR_BANK_C   5'h07
`define GIO_ADDR_BANK_D   5'h08
`define GIO_ADDR_BANK_E   5'h09

// Bank count and index of each bank
`define GIO_BANKS         5
`define GIO_BANK_A        3'h0
`define GIO_BANK_B        3'h1
`define GIO_BANK_C        3'h2
`define GIO_BANK_D        3'h3
`define GIO_BANK_E        3'h4

// Pins that exist in each bank
`define GIO_MASK_A        8'h0F
`define GIO_MASK_B        8'hFF
`define GIO_MASK_C        8'hFF
`define GIO_MASK_D        8'hFF
`define GIO_MASK_E        8'hF0
`define GIO_MASK_NONE     8'h00
`define GIO_MASK_ALL      8'hFF

// Reset values
`define GIO_DIR_RESET     8'hFF
`define GIO_LATCH_RESET   8'h00
`define GIO_DATA_RESET    8'h00

// Family member codes
`define GIO_FAMILY_W      2
`define GIO_FAMILY_SMALL  2'h0
`define GIO_FAMILY_MID    2'h1
`define GIO_FAMILY_LARGE  2'h2

`endif

// file: rtl/gio_ports.v
// General purpose I/O ports: data latches, direction registers and pin read path
//
// Contract
// R01 - A port read returns the sampled pin levels whatever the direction, never the output latch; storage banks here return their latch.
// R02 - Any reset sets every bit of all five direction registers so every pin is a high-impedance input.
// R03 - Bank a has pins only in bits 3 to 0 and its bits 7 to 4 always read as zero.
// R04 - Bank b has all eight bits as bidirectional pins.
// R05 - Bank c is an eight-bit pin register on the mid and large members and plain storage on the small one.
// R06 - Bank d is an eight-bit pin register only on the large member and plain storage otherwise.
// R07 - Bank e exists only on the large member with pins in bits 7 to 4, low bits reading zero, else storage.
// R08 - The direction-load instruction copies the working register into the named bank's direction register only.
// R09 - A direction bit at one turns the pin driver off, leaving the pin a high-impedance input.
// R10 - A direction bit at zero turns the driver on and drives the pin with the output latch bit.
// R11 - A pin driven high but held low outside reads back low.
// R12 - Direction registers have no read path and are forced to all ones on reset.
// R13 - Output latches keep their value until the port is written again, whatever the direction does.
// R14 - A port write takes effect at the end of the cycle and a port read samples the pins at its start.
// R15 - Direction bits of missing pin positions are accepted but drive nothing.
`timescale 1ns/1ps
`include "gio_map.vh"

module gio_ports #(
   parameter [`GIO_FAMILY_W-1:0] FAMILY = `GIO_FAMILY_LARGE
) (
   input  wire                   clk,
   input  wire                   reset,
   input  wire                   wr_en,
   input  wire [`GIO_ADDR_W-1:0] wr_addr,
   input  wire [7:0]             wr_data,
   input  wire                   rd_en,
   input  wire [`GIO_ADDR_W-1:0] rd_addr,
   output wire [7:0]             rd_data,
   output wire                   rd_hit,
   input  wire                   dir_load,
   input  wire [`GIO_ADDR_W-1:0] dir_addr,
   input  wire [7:0]             w_value,
   input  wire [7:0]             bank_a_in,
   output wire [7:0]             bank_a_out,
   output wire [7:0]             bank_a_oe,
   input  wire [7:0]             bank_b_in,
   output wire [7:0]             bank_b_out,
   output wire [7:0]             bank_b_oe,
   input  wire [7:0]             bank_c_in,
   output wire [7:0]             bank_c_out,
   output wire [7:0]             bank_c_oe,
   input  wire [7:0]             bank_d_in,
   output wire [7:0]             bank_d_out,
   output wire [7:0]             bank_d_oe,
   input  wire [7:0]             bank_e_in,
   output wire [7:0]             bank_e_out,
   output wire [7:0]             bank_e_oe
);

   // Decode of a file address into a one-hot bank select, shared by all three paths
   function [`GIO_BANKS-1:0] bank_sel;
      input [`GIO_ADDR_W-1:0] addr;
      begin
         case (addr)
            `GIO_ADDR_BANK_A: bank_sel = 5'h01;
            `GIO_ADDR_BANK_B: bank_sel = 5'h02;
            `GIO_ADDR_BANK_C: bank_sel = 5'h04;
            `GIO_ADDR_BANK_D: bank_sel = 5'h08;
            `GIO_ADDR_BANK_E: bank_sel = 5'h10;
            default:          bank_sel = 5'h00;
         endcase
      end
   endfunction

   // Pins that exist in a bank on this family member; none means plain storage
   function [7:0] pin_mask;
      input [2:0]               bank;
      input [`GIO_FAMILY_W-1:0] fam;
      begin
         case (bank)
            `GIO_BANK_A: pin_mask = `GIO_MASK_A;                                              // R03
            `GIO_BANK_B: pin_mask = `GIO_MASK_B;                                              // R04
            `GIO_BANK_C: pin_mask = (fam == `GIO_FAMILY_SMALL) ? `GIO_MASK_NONE : `GIO_MASK_C; // R05
            `GIO_BANK_D: pin_mask = (fam == `GIO_FAMILY_LARGE) ? `GIO_MASK_D : `GIO_MASK_NONE; // R06
            `GIO_BANK_E: pin_mask = (fam == `GIO_FAMILY_LARGE) ? `GIO_MASK_E : `GIO_MASK_NONE; // R07
            default:     pin_mask = `GIO_MASK_NONE;
         endcase
      end
   endfunction

   wire [`GIO_BANKS-1:0] wr_sel;
   wire [`GIO_BANKS-1:0] rd_sel;
   wire [`GIO_BANKS-1:0] dir_sel;
   wire [8*`GIO_BANKS-1:0] pins_in;
   wire [8*`GIO_BANKS-1:0] pins_out;
   wire [8*`GIO_BANKS-1:0] pins_oe;
   wire [8*`GIO_BANKS-1:0] bank_view;
   reg  [7:0]             rd_data_reg;
   reg  [7:0]             rd_data_next;
   reg                    rd_hit_reg;
   integer                i;

   assign wr_sel  = wr_en    ? bank_sel(wr_addr)  : {`GIO_BANKS{1'b0}};
   assign rd_sel  = rd_en    ? bank_sel(rd_addr)  : {`GIO_BANKS{1'b0}};
   assign dir_sel = dir_load ? bank_sel(dir_addr) : {`GIO_BANKS{1'b0}};
   assign pins_in = {bank_e_in, bank_d_in, bank_c_in, bank_b_in, bank_a_in};

   // One slice per bank: latch, direction and pin drive
   genvar g;
   generate
      for (g = 0; g < `GIO_BANKS; g = g + 1) begin : bank
         localparam [31:0] IDX_FULL = g;
         localparam [2:0]  IDX      = IDX_FULL[2:0];  // Bank index fits three bits
         wire [7:0] mask = pin_mask(IDX, FAMILY);
         reg  [7:0] latch_reg;
         reg  [7:0] dir_reg;

         // Latch only moves on its own write, so a direction change never disturbs it
         always @(posedge clk) begin
            if (reset) begin
               latch_reg <= `GIO_LATCH_RESET;
            end else if (wr_sel[g]) begin
               latch_reg <= wr_data;                  // R13 R14
            end
         end

         // Reachable only from the direction-load instruction, never from a data write
         always @(posedge clk) begin
            if (reset) begin
               dir_reg <= `GIO_DIR_RESET;            // R02 R12
            end else if (dir_sel[g]) begin
               dir_reg <= w_value;                   // R08 R15
            end
         end

         // Missing pins are never driven whatever their direction bit holds
         assign pins_oe[8*g+7:8*g]  = ~dir_reg & mask;          // R09 R10 R15
         assign pins_out[8*g+7:8*g] = latch_reg & ~dir_reg & mask; // R10

         // Pin banks read the pins; storage banks read their latch
         assign bank_view[8*g+7:8*g] = (mask == `GIO_MASK_NONE) ? latch_reg :
                                       (pins_in[8*g+7:8*g] & mask); // R01 R03 R07 R11
      end
   endgenerate

   assign bank_a_out = pins_out[7:0];
   assign bank_a_oe  = pins_oe[7:0];
   assign bank_b_out = pins_out[15:8];
   assign bank_b_oe  = pins_oe[15:8];
   assign bank_c_out = pins_out[23:16];
   assign bank_c_oe  = pins_oe[23:16];
   assign bank_d_out = pins_out[31:24];
   assign bank_d_oe  = pins_oe[31:24];
   assign bank_e_out = pins_out[39:32];
   assign bank_e_oe  = pins_oe[39:32];

   // Read mux; unmapped addresses and idle cycles give zero
   always @* begin
      rd_data_next = `GIO_DATA_RESET;
      for (i = 0; i < `GIO_BANKS; i = i + 1) begin
         if (rd_sel[i]) begin
            rd_data_next = bank_view[8*i +: 8];      // R01
         end
      end
   end

   // Pins sampled at the edge that closes the read cycle, the edge a same-cycle write also lands on, so that write is not yet visible
   always @(posedge clk) begin
      if (reset) begin
         rd_data_reg <= `GIO_DATA_RESET;
         rd_hit_reg  <= 1'b0;
      end else begin
         rd_data_reg <= rd_data_next;                // R14
         rd_hit_reg  <= |rd_sel;
      end
   end

   assign rd_data = rd_data_reg;
   assign rd_hit  = rd_hit_reg;

endmodule

// file: verif/gio_props.sv
// Checker for the general I/O port block
`timescale 1ns/1ps
module gio_props #(
   parameter [1:0] FAMILY = 2'h2
) (
   input wire       clk,
   input wire       reset,
   input wire       rd_en,
   input wire [4:0] rd_addr,
   input wire [7:0] rd_data,
   input wire       rd_hit,
   input wire       dir_load,
   input wire [4:0] dir_addr,
   input wire [7:0] w_value,
   input wire [7:0] bank_a_oe,
   input wire [7:0] bank_b_in,
   input wire [7:0] bank_b_out,
   input wire [7:0] bank_b_oe,
   input wire [7:0] bank_e_oe
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // Read of one of the five bank addresses
   wire map_rd = rd_en && rd_addr >= 5'h05 && rd_addr <= 5'h09;
   dir_reset_a: assert property (disable iff (1'b0) reset |=> bank_b_oe == 8'h00)
      else $error("driver on after reset");
   read_hit_a: assert property (map_rd |=> rd_hit) else $error("mapped read not flagged");
   pin_read_a: assert property (rd_en && rd_addr == 5'h06 |=> rd_data == $past(bank_b_in))
      else $error("bank b read not pins");
   a_high_a: assert property (rd_en && rd_addr == 5'h05 |=> rd_data[7:4] == 4'h0)
      else $error("bank a high bits set");
   e_low_a: assert property (FAMILY == 2'h2 && rd_en && rd_addr == 5'h09 |=> rd_data[3:0] == 4'h0)
      else $error("bank e low bits set");
   idle_read_a: assert property (!rd_en |=> rd_data == 8'h00 && !rd_hit) else $error("stray read data");
   dir_copy_a: assert property (dir_load && dir_addr == 5'h06 |=> bank_b_oe == ~$past(w_value))
      else $error("direction not loaded");
   missing_pin_a: assert property (bank_a_oe[7:4] == 4'h0 && bank_e_oe[3:0] == 4'h0)
      else $error("missing pin driven");
   off_drive_a: assert property ((bank_b_out & ~bank_b_oe) == 8'h00) else $error("output without enable");
   // Main scenarios
   cover property (map_rd);
   cover property (dir_load && w_value == 8'h00);
   cover property (rd_hit && rd_data != 8'h00);
   cover property (FAMILY == 2'h0 && rd_en && rd_addr == 5'h07);
endmodule

bind gio_ports gio_props #(.FAMILY(FAMILY)) gio_props_inst (.clk, .reset, .rd_en, .rd_addr, .rd_data, .rd_hit, .dir_load,
   .dir_addr, .w_value, .bank_a_oe, .bank_b_in, .bank_b_out, .bank_b_oe, .bank_e_oe);

// file: verif/gio_ext_model.sv
// External circuitry model on the port pins
`timescale 1ns/1ps
module gio_ext_model (
   input  wire [39:0] out,
   input  wire [39:0] oe,
   input  wire [39:0] ext,
   input  wire [39:0] hold,
   output wire [39:0] pins
);
   // Driven bits follow the latch, others the outside level; a hard pull-down wins
   assign pins = ((oe & out) | (~oe & ext)) & ~hold;
endmodule

// file: verif/test_gio_ports.sv
// Testbench of the general I/O port block
`timescale 1ns/1ps
`define CHK(x, y) begin tests_run++; if ((x) !== (y)) begin failures++; $display("[FAIL] %0t got %h exp %h", $time, x, y); end end
module test_gio_ports;
   typedef struct packed {logic [4:0] a; logic [7:0] dir, lat, ext, hold, rd, oe;} gio_row_t;
   logic        clk = 1'b0, reset = 1'b1, wr_en = 1'b0, rd_en = 1'b0, dir_load = 1'b0;
   logic [4:0]  a = 5'h00;
   logic [7:0]  d = 8'h00;
   logic [39:0] ext = 40'h0, hold = 40'h0;
   wire  [39:0] out, oe, pins;
   wire  [7:0]  rd_data;
   wire         rd_hit;
   wire  [39:0] s_out, s_oe;
   wire  [7:0]  s_rd;
   wire         s_hit;
   int          failures = 0, tests_run = 0;
   gio_row_t    rows [5] = '{
      '{5'h05, 8'h00, 8'hFF, 8'hF0, 8'h00, 8'h0F, 8'h0F},
      '{5'h06, 8'h0F, 8'hA5, 8'h03, 8'h00, 8'hA3, 8'hF0},
      '{5'h07, 8'hFF, 8'h5A, 8'hC3, 8'h00, 8'hC3, 8'h00},
      '{5'h08, 8'h00, 8'h3C, 8'h00, 8'h0F, 8'h30, 8'hFF},
      '{5'h09, 8'h00, 8'hFF, 8'h0F, 8'h00, 8'hF0, 8'hF0}};
   always #12.5 clk = ~clk;
   gio_ports gio_ports_inst (.clk(clk), .reset(reset), .wr_en(wr_en), .wr_addr(a), .wr_data(d), .rd_en(rd_en),
      .rd_addr(a), .rd_data(rd_data), .rd_hit(rd_hit), .dir_load(dir_load), .dir_addr(a), .w_value(d),
      .bank_a_in(pins[7:0]), .bank_a_out(out[7:0]), .bank_a_oe(oe[7:0]),
      .bank_b_in(pins[15:8]), .bank_b_out(out[15:8]), .bank_b_oe(oe[15:8]),
      .bank_c_in(pins[23:16]), .bank_c_out(out[23:16]), .bank_c_oe(oe[23:16]),
      .bank_d_in(pins[31:24]), .bank_d_out(out[31:24]), .bank_d_oe(oe[31:24]),
      .bank_e_in(pins[39:32]), .bank_e_out(out[39:32]), .bank_e_oe(oe[39:32]));
   gio_ext_model gio_ext_model_inst (.out(out), .oe(oe), .ext(ext), .hold(hold), .pins(pins));
   // Smallest member on the same bus; its pins see the outside level only
   gio_ports #(.FAMILY(2'h0)) gio_ports_small_inst (.clk(clk), .reset(reset), .wr_en(wr_en), .wr_addr(a),
      .wr_data(d), .rd_en(rd_en), .rd_addr(a), .rd_data(s_rd), .rd_hit(s_hit), .dir_load(dir_load),
      .dir_addr(a), .w_value(d),
      .bank_a_in(ext[7:0]), .bank_a_out(s_out[7:0]), .bank_a_oe(s_oe[7:0]),
      .bank_b_in(ext[15:8]), .bank_b_out(s_out[15:8]), .bank_b_oe(s_oe[15:8]),
      .bank_c_in(ext[23:16]), .bank_c_out(s_out[23:16]), .bank_c_oe(s_oe[23:16]),
      .bank_d_in(ext[31:24]), .bank_d_out(s_out[31:24]), .bank_d_oe(s_oe[31:24]),
      .bank_e_in(ext[39:32]), .bank_e_out(s_out[39:32]), .bank_e_oe(s_oe[39:32]));
   // One instruction cycle, set up on the falling edge
   task cyc(input logic w, r, l, input logic [4:0] ad, input logic [7:0] v);
      @(negedge clk);
      {wr_en, rd_en, dir_load, a, d} = {w, r, l, ad, v};
   endtask
   // Read leaves the answer standing in its one valid cycle
   task rd(input logic [4:0] ad);
      cyc(1'b0, 1'b1, 1'b0, ad, 8'h00);
      cyc(1'b0, 1'b0, 1'b0, ad, 8'h00);
   endtask
   task results;
      $display("failures=%0d tests_run=%0d", failures, tests_run);
      if (failures == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Watchdog, far beyond the sixty or so cycles needed
   initial begin
      #100000;
      failures++;
      results;
   end
   initial begin
      repeat (2) @(posedge clk);
      @(negedge clk) reset = 1'b0;
      `CHK(oe, 40'h0)
      rd(5'h1F);
      `CHK({rd_hit, rd_data}, 9'h000)
      cyc(1'b0, 1'b0, 1'b1, 5'h06, 8'h00);
      rd(5'h06);
      `CHK(rd_data, 8'h00)
      // Table rows: direction, latch, outside level, read and enables
      foreach (rows[i]) begin
         ext = {5{rows[i].ext}};
         hold = {5{rows[i].hold}};
         cyc(1'b0, 1'b0, 1'b1, rows[i].a, rows[i].dir);
         cyc(1'b1, 1'b0, 1'b0, rows[i].a, rows[i].lat);
         rd(rows[i].a);
         `CHK(rd_data, rows[i].rd)
         `CHK(rd_hit, 1'b1)
         `CHK(oe[(rows[i].a - 5) * 8 +: 8], rows[i].oe)
      end
      // Latch survives a direction round trip
      cyc(1'b0, 1'b0, 1'b1, 5'h06, 8'hFF);
      cyc(1'b0, 1'b0, 1'b1, 5'h06, 8'h00);
      rd(5'h06);
      `CHK(rd_data, 8'hA5)
      // Write and read in one cycle see the old pins
      cyc(1'b1, 1'b1, 1'b0, 5'h06, 8'h11);
      cyc(1'b0, 1'b0, 1'b0, 5'h06, 8'h00);
      `CHK(rd_data, 8'hA5)
      rd(5'h06);
      `CHK(rd_data, 8'h11)
      // Data write never reaches the direction bits
      ext = {5{8'h96}};
      cyc(1'b0, 1'b0, 1'b1, 5'h06, 8'hFF);
      cyc(1'b1, 1'b0, 1'b0, 5'h06, 8'h00);
      rd(5'h06);
      `CHK(oe[15:8], 8'h00)
      `CHK(rd_data, 8'h96)
      // Smallest member: banks c to e keep a byte, ignore their pins and drive nothing
      ext = {5{8'h0F}};
      for (int k = 7; k <= 9; k++) begin
         cyc(1'b0, 1'b0, 1'b1, k[4:0], 8'h00);
         cyc(1'b1, 1'b0, 1'b0, k[4:0], 8'hC5);
         rd(k[4:0]);
         `CHK({s_hit, s_rd}, 9'h1C5)
         `CHK({s_out[39:16], s_oe[39:16]}, 48'h0)
      end
      // Second reset in mid-run
      @(negedge clk) reset = 1'b1;
      repeat (2) @(negedge clk);
      reset = 1'b0;
      `CHK(oe, 40'h0)
      `CHK(s_oe, 40'h0)
      results;
   end
endmodule
